// >>> rsgac_pkg.sv
// Register map, reset values, carrier types and decoders of the settle, scale and gain bank.
package rsgac_pkg;
  // Register indices; the Wishbone byte address is four times the index.
  localparam int unsigned IDX_W = 6;
  localparam int unsigned IDX_LSB = 2;
  localparam logic [5:0] IDX_RES = 6'h0f;
  localparam logic [5:0] IDX_SETTLE = 6'h12;
  localparam logic [5:0] IDX_SCALE = 6'h13;
  localparam logic [5:0] IDX_RSVD = 6'h14;
  localparam logic [5:0] IDX_FTGC = 6'h15;
  localparam logic [5:0] IDX_CSUM3 = 6'h16;
  localparam logic [5:0] IDX_CSUM2 = 6'h17;
  localparam logic [5:0] IDX_STAT = 6'h30;
  localparam logic [5:0] IDX_EDV = 6'h31;

  // Values after reset.
  localparam logic [7:0] RST_SETTLE = 8'h23;
  localparam logic [7:0] RST_SCALE = 8'h0c;
  localparam logic [7:0] RST_FTGC = 8'h0f;
  localparam logic [7:0] RST_CSUM3 = 8'h00;
  localparam logic [7:0] RST_CSUM2 = 8'h00;
  localparam logic RST_RES = 1'b0;
  localparam logic [3:0] RST_GAIN = 4'hf;

  // Field positions and masks of the writable bits; reserved bits stay zero.
  localparam int unsigned FAST_LSB = 4;
  localparam int unsigned GEN_LSB = 0;
  localparam int unsigned FT_EN_BIT = 7;
  localparam logic [7:0] WMASK_SETTLE = 8'h77;
  localparam logic [7:0] WMASK_SCALE = 8'h1f;
  localparam logic [7:0] WMASK_FTGC = 8'h8f;
  localparam logic [7:0] WMASK_CSUM3 = 8'h7f;
  localparam logic [7:0] WMASK_CSUM2 = 8'hff;

  // Weights are held in eighths; full resolution spends eight clocks per sample and bandwidth step.
  localparam int unsigned SCALE_SHIFT = 3;
  localparam int unsigned FULL_SHIFT = 3;
  localparam int unsigned HALF_SHIFT = 2;
  localparam logic [7:0] ENERGY_MAX = 8'hff;

  // Settling configuration carried from the registers to the timer.
  typedef struct packed {
    logic [2:0] fast;
    logic [2:0] gen;
    logic half;
    logic [6:0] bw;
  } rsgac_settle_cfg_t;

  // Gain levels that the gain control may use.
  typedef struct packed {
    logic low;
    logic mid;
    logic high;
    logic highest;
  } rsgac_gain_set_t;

  // Sample count selected by a 3-bit settling code.
  function automatic logic [7:0] rsgac_samples(input logic [2:0] code);
    case (code)
      3'h0: rsgac_samples = 8'd50;
      3'h1: rsgac_samples = 8'd100;
      3'h2: rsgac_samples = 8'd125;
      3'h3: rsgac_samples = 8'd150;
      3'h4: rsgac_samples = 8'd175;
      3'h5: rsgac_samples = 8'd200;
      3'h6: rsgac_samples = 8'd225;
      default: rsgac_samples = 8'd250;
    endcase
  endfunction : rsgac_samples

  // Allowed gain levels for a gain mode code; unlisted codes fix high gain.
  function automatic rsgac_gain_set_t rsgac_gain_decode(input logic [3:0] mode);
    case (mode)
      4'h1: rsgac_gain_decode = 4'b0001;
      4'h3: rsgac_gain_decode = 4'b0011;
      4'h4: rsgac_gain_decode = 4'b0110;
      4'h6, 4'hb: rsgac_gain_decode = 4'b0111;
      4'h8: rsgac_gain_decode = 4'b1100;
      4'he: rsgac_gain_decode = 4'b1110;
      4'hf: rsgac_gain_decode = 4'b1111;
      default: rsgac_gain_decode = 4'b0010;
    endcase
  endfunction : rsgac_gain_decode
endpackage : rsgac_pkg

// >>> rsgac_settle_timer.sv
// Settling timer that blanks signal-strength readings after each gain switch.
`timescale 1ns/1ps
`default_nettype none
module rsgac_settle_timer
  import rsgac_pkg::*;
#(
  parameter int unsigned CNT_W = 18
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Configuration and events.
  input wire rsgac_settle_cfg_t cfg_i,
  input wire logic fast_check_i,
  input wire logic gain_switch_i,
  // Status.
  output logic settling_o
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic settle_r;
  logic settle_nxt;
  logic [7:0] samples;
  logic [14:0] base;
  logic [CNT_W-1:0] target;

  // Shorter counters cannot hold the longest settling length.
  if (CNT_W < 18) begin : g_bad_cnt_w
    $error("CNT_W too small for the longest settling time");
  end

  // Length in clocks: samples times bandwidth adjust times eight, halved at half resolution.
  always_comb begin
    samples = rsgac_samples(fast_check_i ? cfg_i.fast : cfg_i.gen);
    base = 15'(samples) * 15'(cfg_i.bw);
    target = cfg_i.half ? CNT_W'({base, 2'b00}) : CNT_W'({base, 3'b000});
  end

  // A gain switch restarts the count, otherwise it runs down to zero.
  always_comb begin
    cnt_nxt = cnt_r;
    if (gain_switch_i) begin
      cnt_nxt = target;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - CNT_W'(1);
    end
    settle_nxt = (cnt_nxt != '0);
  end

  // Count and settling flag registers.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= '0;
      settle_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      settle_r <= settle_nxt;
    end
  end

  assign settling_o = settle_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  a_settle_load: assert property (gain_switch_i |=> cnt_r == $past(target)
    && settling_o == ($past(target) != '0))
    else $error("settling count not loaded from the selected length");
  a_half_length: assert property (gain_switch_i && !fast_check_i && cfg_i.gen == 3'h0
    && cfg_i.half && cfg_i.bw == 7'h01 |=> cnt_r == CNT_W'(200))
    else $error("half resolution length wrong");
endmodule : rsgac_settle_timer
`default_nettype wire

// >>> rsgac_energy_scale.sv
// Scaler that turns signal strength into a saturated energy-detection value.
`timescale 1ns/1ps
`default_nettype none
module rsgac_energy_scale
  import rsgac_pkg::*;
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Samples, weights and blanking.
  input wire logic [7:0] rssi_i,
  input wire logic rssi_valid_i,
  input wire logic [4:0] weights_i,
  input wire logic block_i,
  // Result.
  output logic [7:0] value_o,
  output logic valid_o
);
  logic [7:0] value_r;
  logic [7:0] value_nxt;
  logic valid_r;
  logic valid_nxt;
  logic [12:0] prod;
  logic [9:0] scaled;
  logic take;

  // Weights in eighths equal the weight bits read as a number, so one product sums them.
  always_comb begin
    prod = 13'(rssi_i) * 13'(weights_i);
    scaled = prod[12:SCALE_SHIFT];
    take = rssi_valid_i && !block_i;
    valid_nxt = take;
    value_nxt = value_r;
    if (take) begin
      value_nxt = (scaled[9:8] != 2'b00) ? ENERGY_MAX : scaled[7:0];
    end
  end

  // Result registers.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      value_r <= 8'h00;
      valid_r <= 1'b0;
    end else begin
      value_r <= value_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign value_o = value_r;
  assign valid_o = valid_r;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  a_sat_limit: assert property (take && prod > 13'h07ff |=>
    valid_o && value_o == 8'hff)
    else $error("energy value did not saturate");
  a_scale_sum: assert property (take && prod <= 13'h07ff |=>
    value_o == $past(prod[10:3]))
    else $error("energy value is not the weighted sum");
  a_unit_weight: assert property (take && weights_i == 5'h08 |=>
    value_o == $past(rssi_i))
    else $error("unit weight changed the reading");
endmodule : rsgac_energy_scale
`default_nettype wire

// >>> rsgac_config.sv
// Wishbone register bank for settling time, energy scale, frequency tracking and gain mode.
// Summary of operation
// - Bits 6:4 pick fast-check settling samples: 50,100,125..250.
// - Signal-strength readings during settling never enter the energy value.
// - Settling clocks equal samples times bandwidth adjust times eight.
// - Scale bits 4..0 enable weights 2, 1, 1/2, 1/4, 1/8.
// - Applied scale is the sum of the enabled weights.
// - Scaled energy above 255 saturates at 255.
// - Gain mode codes select fixed or allowed sets of gain levels.
// - Unlisted gain codes fix high gain; reset allows all four.
// - Top checksum register bits 6:0 hold polynomial 30:24, bit 7 zero.
// - Resolution bit set halves the settling time.
// - Next checksum register holds polynomial bits 23:16.
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module rsgac_config
  import rsgac_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Receiver inputs on the same clock.
  input wire logic [6:0] filter_bandwidth_adjust_i,
  input wire logic fast_check_i,
  input wire logic gain_switch_i,
  input wire logic [7:0] rssi_i,
  input wire logic rssi_valid_i,
  // Configuration and results.
  output logic freq_track_enable_o,
  output logic [3:0] gain_mode_select_o,
  output rsgac_gain_set_t gain_allowed_o,
  output logic [30:16] checksum_polynomial_o,
  output logic settling_o,
  output logic [7:0] energy_detect_value_o,
  output logic energy_valid_o
);
  logic ack_r;
  logic ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic [7:0] settle_r;
  logic [7:0] settle_nxt;
  logic [7:0] scale_r;
  logic [7:0] scale_nxt;
  logic [7:0] ftgc_r;
  logic [7:0] ftgc_nxt;
  logic [7:0] csum3_r;
  logic [7:0] csum3_nxt;
  logic [7:0] csum2_r;
  logic [7:0] csum2_nxt;
  logic res_r;
  logic res_nxt;
  rsgac_gain_set_t gain_r;
  rsgac_gain_set_t gain_nxt;
  logic [IDX_W-1:0] idx;
  logic req;
  logic wr_go;
  logic [7:0] rd_byte;
  rsgac_settle_cfg_t settle_cfg;

  // Only an 8-bit byte address fits the six-bit register index.
  if (ADDR_W != IDX_W + IDX_LSB) begin : g_bad_addr_w
    $error("ADDR_W must be 8");
  end

  assign idx = wb_adr_i[ADDR_W-1:IDX_LSB];
  assign req = wb_cyc_i && wb_stb_i;
  // A write lands at the edge on which the master sees the acknowledge.
  assign wr_go = req && wb_we_i && ack_r && wb_sel_i[0] && (wb_adr_i[1:0] == 2'b00);

  // Read multiplexer; unmapped and reserved addresses read zero.
  always_comb begin
    rd_byte = 8'h00;
    if (wb_adr_i[1:0] != 2'b00) begin
      rd_byte = 8'h00;
    end else if (idx == IDX_RES) begin
      rd_byte = {7'h00, res_r};
    end else if (idx == IDX_SETTLE) begin
      rd_byte = settle_r;
    end else if (idx == IDX_SCALE) begin
      rd_byte = scale_r;
    end else if (idx == IDX_FTGC) begin
      rd_byte = ftgc_r;
    end else if (idx == IDX_CSUM3) begin
      rd_byte = csum3_r;
    end else if (idx == IDX_CSUM2) begin
      rd_byte = csum2_r;
    end else if (idx == IDX_STAT) begin
      rd_byte = {gain_r, 3'b000, settling_o};
    end else if (idx == IDX_EDV) begin
      rd_byte = energy_detect_value_o;
    end
  end

  // Bus answer: acknowledge one cycle after the request, dropped the cycle after.
  always_comb begin
    ack_nxt = req && !ack_r;
    dat_nxt = ack_nxt ? {24'h000000, rd_byte} : 32'h00000000;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // Register writes; only the writable bits are stored, so reserved bits stay zero.
  always_comb begin
    settle_nxt = settle_r;
    scale_nxt = scale_r;
    ftgc_nxt = ftgc_r;
    csum3_nxt = csum3_r;
    csum2_nxt = csum2_r;
    res_nxt = res_r;
    if (wr_go) begin
      if (idx == IDX_RES) begin
        res_nxt = wb_dat_i[0];
      end else if (idx == IDX_SETTLE) begin
        settle_nxt = wb_dat_i[7:0] & WMASK_SETTLE;
      end else if (idx == IDX_SCALE) begin
        scale_nxt = wb_dat_i[7:0] & WMASK_SCALE;
      end else if (idx == IDX_FTGC) begin
        ftgc_nxt = wb_dat_i[7:0] & WMASK_FTGC;
      end else if (idx == IDX_CSUM3) begin
        csum3_nxt = wb_dat_i[7:0] & WMASK_CSUM3;
      end else if (idx == IDX_CSUM2) begin
        csum2_nxt = wb_dat_i[7:0] & WMASK_CSUM2;
      end
    end
    gain_nxt = rsgac_gain_decode(ftgc_nxt[3:0]);
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      settle_r <= RST_SETTLE;
      scale_r <= RST_SCALE;
      ftgc_r <= RST_FTGC;
      csum3_r <= RST_CSUM3;
      csum2_r <= RST_CSUM2;
      res_r <= RST_RES;
      gain_r <= RST_GAIN;
    end else begin
      settle_r <= settle_nxt;
      scale_r <= scale_nxt;
      ftgc_r <= ftgc_nxt;
      csum3_r <= csum3_nxt;
      csum2_r <= csum2_nxt;
      res_r <= res_nxt;
      gain_r <= gain_nxt;
    end
  end

  // Configuration outputs straight from the registers.
  assign freq_track_enable_o = ftgc_r[FT_EN_BIT];
  assign gain_mode_select_o = ftgc_r[3:0];
  assign gain_allowed_o = gain_r;
  assign checksum_polynomial_o = {csum3_r[6:0], csum2_r};

  // Settling configuration for the timer.
  always_comb begin
    settle_cfg.fast = settle_r[FAST_LSB +: 3];
    settle_cfg.gen = settle_r[GEN_LSB +: 3];
    settle_cfg.half = res_r;
    settle_cfg.bw = filter_bandwidth_adjust_i;
  end

  rsgac_settle_timer #(
    .CNT_W(18)
  ) u_timer (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .cfg_i(settle_cfg),
    .fast_check_i(fast_check_i),
    .gain_switch_i(gain_switch_i),
    .settling_o(settling_o)
  );

  rsgac_energy_scale u_scale (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .rssi_i(rssi_i),
    .rssi_valid_i(rssi_valid_i),
    .weights_i(scale_r[4:0]),
    .block_i(settling_o),
    .value_o(energy_detect_value_o),
    .valid_o(energy_valid_o)
  );

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_write(logic [5:0] at);
    wr_go && idx == at;
  endsequence

  sequence s_read(logic [5:0] at);
    wb_ack_o && !wb_we_i && idx == at && wb_adr_i[1:0] == 2'b00;
  endsequence

  a_track_write: assert property (s_write(IDX_FTGC) |=>
    freq_track_enable_o == $past(wb_dat_i[7]))
    else $error("frequency tracking enable did not follow the write");
  // Gain decode: every listed code gives its set of levels; codes 6 and b give the same one.
  a_gain_full: assert property (gain_mode_select_o == 4'hf |->
    gain_allowed_o == 4'b1111)
    else $error("gain code 1111 does not allow all levels");
  a_gain_pair: assert property (gain_mode_select_o == 4'h3 |->
    gain_allowed_o == 4'b0011)
    else $error("gain code 0011 wrong");
  a_gain_top: assert property (gain_mode_select_o == 4'h1 |->
    gain_allowed_o == 4'b0001)
    else $error("gain code 0001 does not fix the highest gain");
  a_gain_high: assert property (gain_mode_select_o == 4'h2 |->
    gain_allowed_o == 4'b0010)
    else $error("gain code 0010 does not fix high gain");
  a_gain_mid: assert property (gain_mode_select_o == 4'h4 |->
    gain_allowed_o == 4'b0110)
    else $error("gain code 0100 wrong");
  a_gain_three: assert property (gain_mode_select_o inside {4'h6, 4'hb} |->
    gain_allowed_o == 4'b0111)
    else $error("gain codes 0110 and 1011 wrong");
  a_gain_low: assert property (gain_mode_select_o == 4'h8 |->
    gain_allowed_o == 4'b1100)
    else $error("gain code 1000 wrong");
  a_gain_lmh: assert property (gain_mode_select_o == 4'he |->
    gain_allowed_o == 4'b1110)
    else $error("gain code 1110 wrong");
  a_gain_other: assert property (!(gain_mode_select_o inside {4'h1, 4'h3, 4'h4, 4'h6,
    4'h8, 4'hb, 4'he, 4'hf}) |-> gain_allowed_o == 4'b0010)
    else $error("unlisted gain code does not fix high gain");
  a_csum_top: assert property (s_write(IDX_CSUM3) |=>
    checksum_polynomial_o[30:24] == $past(wb_dat_i[6:0]) && csum3_r[7] == 1'b0)
    else $error("top polynomial bits wrong");
  a_csum_next: assert property (s_write(IDX_CSUM2) |=>
    checksum_polynomial_o[23:16] == $past(wb_dat_i[7:0]))
    else $error("polynomial bits 23:16 wrong");
  a_rsvd_zero: assert property (s_read(IDX_RSVD) |-> wb_dat_o == 32'h00000000)
    else $error("reserved register read nonzero");
  a_settle_rsvd: assert property (s_read(IDX_SETTLE) |-> wb_dat_o[7] == 1'b0
    && wb_dat_o[3] == 1'b0)
    else $error("reserved settling bits read nonzero");
  a_blank_settle: assert property (settling_o && rssi_valid_i |=> !energy_valid_o
    && $stable(energy_detect_value_o))
    else $error("reading used while settling");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");

  // Bus answer: one cycle after a fresh request, data only while acknowledged.
  sequence s_new_req;
    req && !ack_r;
  endsequence

  a_ack_answer: assert property (s_new_req |=> wb_ack_o)
    else $error("request not acknowledged in the next cycle");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data not zero outside the acknowledge");
  a_read_settle: assert property (s_read(IDX_SETTLE) |->
    wb_dat_o == {24'h000000, settle_r})
    else $error("settling register read wrong");
  a_read_status: assert property (s_read(IDX_STAT) |->
    wb_dat_o[7:4] == $past(gain_allowed_o) && wb_dat_o[0] == $past(settling_o))
    else $error("status read wrong");

  // Writes store only the writable bits of the addressed register.
  a_settle_write: assert property (s_write(IDX_SETTLE) |=>
    settle_r == ($past(wb_dat_i[7:0]) & WMASK_SETTLE))
    else $error("settling register write wrong");
  a_scale_write: assert property (s_write(IDX_SCALE) |=>
    scale_r == ($past(wb_dat_i[7:0]) & WMASK_SCALE))
    else $error("scale register write wrong");
  a_res_write: assert property (s_write(IDX_RES) |=> res_r == $past(wb_dat_i[0]))
    else $error("resolution bit write wrong");

  // Reserved bits stay zero, and refused writes change nothing.
  a_rsvd_bits: assert property (settle_r[7] == 1'b0 && settle_r[3] == 1'b0
    && scale_r[7:5] == 3'b000 && ftgc_r[6:4] == 3'b000 && csum3_r[7] == 1'b0)
    else $error("reserved register bit set");
  a_rsvd_write: assert property (s_write(IDX_RSVD) |=>
    $stable({settle_r, scale_r, ftgc_r, csum3_r, csum2_r, res_r}))
    else $error("write to the reserved register changed a register");
  a_lane_off: assert property (req && wb_we_i && ack_r && !wb_sel_i[0] |=>
    $stable({settle_r, scale_r, ftgc_r, csum3_r, csum2_r, res_r}))
    else $error("write with lane zero disabled changed a register");

  // An accepted sample gives a result in the next cycle.
  a_energy_taken: assert property (rssi_valid_i && !settling_o |=> energy_valid_o)
    else $error("accepted sample gave no result");
endmodule : rsgac_config
`default_nettype wire

// >>> rsgac_tb.sv
// Self-checking testbench for the settle, scale and gain register bank.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("mismatch at %0t: %s got %0h expected %0h", $time, msg, got, exp); \
    end \
  end
module testbench
  import rsgac_pkg::*;
;
  // Expected tables: samples per code, allowed gain sets, register resets and masks.
  localparam int SAMP [8] = '{50, 100, 125, 150, 175, 200, 225, 250};
  localparam logic [3:0] GEXP [16] = '{4'h2, 4'h1, 4'h2, 4'h3, 4'h6, 4'h2, 4'h7, 4'h2,
                                       4'hc, 4'h2, 4'h2, 4'h7, 4'h2, 4'h2, 4'he, 4'hf};
  localparam logic [5:0] RIDX [6] = '{6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17};
  localparam logic [7:0] RRST [6] = '{8'h23, 8'h0c, 8'h00, 8'h0f, 8'h00, 8'h00};
  localparam logic [7:0] RMSK [6] = '{8'h77, 8'h1f, 8'h00, 8'h8f, 8'h7f, 8'hff};

  // Design inputs with their time-zero values.
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [6:0] filter_bandwidth_adjust_i = 7'h01;
  logic fast_check_i = 1'b0;
  logic gain_switch_i = 1'b0;
  logic [7:0] rssi_i = 8'h00;
  logic rssi_valid_i = 1'b0;
  // Design outputs.
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic freq_track_enable_o;
  logic [3:0] gain_mode_select_o;
  rsgac_gain_set_t gain_allowed_o;
  logic [30:16] checksum_polynomial_o;
  logic settling_o;
  logic [7:0] energy_detect_value_o;
  logic energy_valid_o;
  int checks = 0;
  int num_errors = 0;
  int i;
  int n;
  logic [31:0] rdv;

  rsgac_config #(.ADDR_W(8)) dut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .filter_bandwidth_adjust_i(filter_bandwidth_adjust_i), .fast_check_i(fast_check_i),
    .gain_switch_i(gain_switch_i), .rssi_i(rssi_i), .rssi_valid_i(rssi_valid_i),
    .freq_track_enable_o(freq_track_enable_o), .gain_mode_select_o(gain_mode_select_o),
    .gain_allowed_o(gain_allowed_o), .checksum_polynomial_o(checksum_polynomial_o),
    .settling_o(settling_o), .energy_detect_value_o(energy_detect_value_o),
    .energy_valid_o(energy_valid_o)
  );

  // The 25 MHz clock toggles every half period.
  always #20 core_clk_i = ~core_clk_i;

  // Byte address of a register index.
  function automatic logic [7:0] ra(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction : ra

  // Expected energy value: weights count in eighths and the result saturates.
  function automatic logic [7:0] energy(input int x, input int w);
    int e;
    e = (x * w) >> 3;
    return (e > 255) ? 8'hff : e[7:0];
  endfunction : energy

  // One classic Wishbone cycle; the request is held until ack is sampled high.
  task automatic wb_access(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                           input logic [3:0] sel, output logic [31:0] rd);
    int k;
    @(posedge core_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, wd};
    wb_sel_i <= sel;
    k = 0;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1) begin
      num_errors++;
      $display("mismatch at %0t: bus acknowledge missing", $time);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_access

  // Full-byte register write.
  task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
    logic [31:0] v;
    wb_access(1'b1, adr, wd, 4'hf, v);
  endtask : wr

  // Register read compared with an expected word.
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp, input string msg);
    logic [31:0] v;
    wb_access(1'b0, adr, 8'h00, 4'hf, v);
    `CHK(v, exp, msg)
  endtask : rd_chk

  // Gain switch pulse, then count the cycles during which settling is reported.
  task automatic settle_run(input logic fast, input int exp_n, input string msg);
    int k;
    @(posedge core_clk_i);
    fast_check_i <= fast;
    gain_switch_i <= 1'b1;
    @(posedge core_clk_i);
    gain_switch_i <= 1'b0;
    k = 0;
    @(posedge core_clk_i);
    while (settling_o === 1'b1 && k < 4000) begin
      k++;
      @(posedge core_clk_i);
    end
    `CHK(k, exp_n, msg)
  endtask : settle_run

  // One signal-strength sample; result is looked at in the cycle after it is taken.
  task automatic sample(input logic [7:0] x, input logic exp_v, input logic [7:0] exp_e,
                        input string msg);
    @(posedge core_clk_i);
    rssi_i <= x;
    rssi_valid_i <= 1'b1;
    @(posedge core_clk_i);
    rssi_valid_i <= 1'b0;
    @(posedge core_clk_i);
    `CHK(energy_valid_o, exp_v, msg)
    `CHK(energy_detect_value_o, exp_e, msg)
  endtask : sample

  // Prints the counts and the verdict, then stops the run.
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  // Watchdog sized well above the roughly 23000 cycles the tests need.
  initial begin
    repeat (60000) @(posedge core_clk_i);
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end

  // Main test sequence.
  initial begin
    repeat (10) @(posedge core_clk_i);
    @(negedge core_clk_i);
    rstn_i <= 1'b1;
    @(negedge core_clk_i);
    `CHK(gain_mode_select_o, 4'hf, "gain mode reset")
    `CHK(gain_allowed_o, 4'hf, "gain set reset")
    `CHK(freq_track_enable_o, 1'b0, "freq track reset")
    `CHK(checksum_polynomial_o, 15'h0, "polynomial reset")
    for (i = 0; i < 6; i++) begin
      rd_chk(ra(RIDX[i]), {24'h0, RRST[i]}, "register reset");
    end
    rd_chk(ra(IDX_RES), 32'h0, "resolution reset");
    $display("test reset values done");
    // Writable bits keep ones, reserved bits and places read zero.
    for (i = 0; i < 6; i++) begin
      wr(ra(RIDX[i]), 8'hff);
      rd_chk(ra(RIDX[i]), {24'h0, RMSK[i]}, "masked readback");
    end
    wr(8'hfc, 8'h5a);
    rd_chk(8'hfc, 32'h0, "unmapped read");
    rd_chk(8'h4d, 32'h0, "misaligned read");
    wb_access(1'b1, ra(IDX_SCALE), 8'h01, 4'he, rdv);
    rd_chk(ra(IDX_SCALE), 32'h1f, "lane zero disabled write");
    wr(ra(IDX_CSUM3), 8'hea);
    wr(ra(IDX_CSUM2), 8'ha5);
    @(negedge core_clk_i);
    `CHK(checksum_polynomial_o, 15'h6aa5, "polynomial bits")
    $display("test access kinds done");
    // Every gain mode code, with frequency tracking toggled alongside.
    for (i = 0; i < 16; i++) begin
      wr(ra(IDX_FTGC), {i[0], 3'h0, i[3:0]});
      @(negedge core_clk_i);
      `CHK(gain_allowed_o, GEXP[i], "gain set")
      `CHK(gain_mode_select_o, i[3:0], "gain mode")
      `CHK(freq_track_enable_o, i[0], "freq track")
    end
    wr(ra(IDX_FTGC), 8'h0f);
    $display("test gain modes done");
    // Settling length for every code of both fields; the register is never zero.
    for (i = 0; i < 8; i++) begin
      wr(ra(IDX_SETTLE), {1'b0, i[2:0], 4'h3});
      settle_run(1'b1, SAMP[i] * 8, "fast settle");
      wr(ra(IDX_SETTLE), {4'h1, 1'b0, i[2:0]});
      settle_run(1'b0, SAMP[i] * 8, "general settle");
    end
    wr(ra(IDX_RES), 8'h01);
    wr(ra(IDX_SETTLE), 8'h10);
    settle_run(1'b0, 200, "half resolution");
    filter_bandwidth_adjust_i <= 7'h03;
    settle_run(1'b1, 1200, "bandwidth three half");
    filter_bandwidth_adjust_i <= 7'h01;
    wr(ra(IDX_RES), 8'h00);
    $display("test settling done");
    // Each weight alone, a sum of weights, and saturation at the boundary.
    for (i = 0; i < 5; i++) begin
      wr(ra(IDX_SCALE), 8'h01 << i);
      sample(8'd100, 1'b1, energy(100, 1 << i), "single weight");
    end
    wr(ra(IDX_SCALE), 8'h0a);
    sample(8'd40, 1'b1, 8'd50, "weight sum");
    wr(ra(IDX_SCALE), 8'h10);
    sample(8'd127, 1'b1, 8'd254, "below saturation");
    sample(8'd128, 1'b1, 8'hff, "saturation edge");
    wr(ra(IDX_SCALE), 8'h1f);
    sample(8'd255, 1'b1, energy(255, 31), "full saturation");
    $display("test energy scale done");
    // Samples taken while settling are dropped and the value is held.
    wr(ra(IDX_SCALE), 8'h10);
    sample(8'd100, 1'b1, 8'd200, "value before switch");
    wr(ra(IDX_SETTLE), 8'h13);
    @(posedge core_clk_i);
    fast_check_i <= 1'b0;
    gain_switch_i <= 1'b1;
    @(posedge core_clk_i);
    gain_switch_i <= 1'b0;
    sample(8'd50, 1'b0, 8'd200, "sample while settling");
    rd_chk(ra(IDX_STAT), 32'hf1, "status while settling");
    rd_chk(ra(IDX_EDV), 32'hc8, "held energy value");
    n = 0;
    while (settling_o === 1'b1 && n < 2000) begin
      n++;
      @(posedge core_clk_i);
    end
    `CHK(settling_o, 1'b0, "settling ended")
    sample(8'd50, 1'b1, 8'd100, "sample after settling");
    $display("test blanking done");
    test_done();
  end
endmodule : testbench
`default_nettype wire
